//--- rtl/ftac_pkg.sv
package ftac_pkg;

	// System clock timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int NS_PER_US = 1000;
	localparam int CLK_PER_US = NS_PER_US / CLK_PERIOD_NS;

	// Nominal pixel clock of the output link, in MHz.
	localparam int PIX_CLK_MHZ = 85;

	// Frame overhead phase length; the figure is a plain default.
	localparam int FOT_TIME_US = 10;
	localparam int FOT_CYCLES = FOT_TIME_US * CLK_PER_US;

	// Datapath widths.
	localparam int EXP_W = 20;
	localparam int CYC_W = 32;
	localparam int DIM_W = 13;
	localparam int MAX_TAPS = 10;
	localparam int TAP_W = 4;
	localparam int TAP_CODE_W = 2;

	// Tap configuration codes and the tap counts they select.
	localparam logic [TAP_CODE_W-1:0] TAP_CODE_2 = 2'h0;
	localparam logic [TAP_CODE_W-1:0] TAP_CODE_4 = 2'h1;
	localparam logic [TAP_CODE_W-1:0] TAP_CODE_8 = 2'h2;
	localparam logic [TAP_CODE_W-1:0] TAP_CODE_10 = 2'h3;
	localparam logic [TAP_W-1:0] TAPS_2 = 4'h2;
	localparam logic [TAP_W-1:0] TAPS_4 = 4'h4;
	localparam logic [TAP_W-1:0] TAPS_8 = 4'h8;
	localparam logic [TAP_W-1:0] TAPS_10 = 4'ha;
	localparam logic [TAP_CODE_W-1:0] RST_TAP_CODE = TAP_CODE_2;

	// Serial tap command: eight bits, MSB first, opcode in the upper nibble.
	localparam int CFG_CMD_W = 8;
	localparam int CFG_CNT_W = 4;
	localparam int CFG_OP_MSB = 7;
	localparam int CFG_OP_LSB = 4;
	localparam logic [3:0] CFG_OP_TAP = 4'ha;
	localparam logic [CFG_CNT_W-1:0] CFG_CMD_BITS = 4'h8;

	typedef enum logic [2:0] {
		EXP_IDLE = 3'b001,
		EXP_ACTIVE = 3'b010,
		EXP_FOT = 3'b100
	} ftac_exp_state_t;

endpackage

//--- rtl/ftac_sync3.sv
`timescale 1ns/100ps
module ftac_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_level
);
	logic meta_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			meta_reg <= i_async;
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
		end
	end

	// A change is accepted only once the last two stages agree.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_level <= RST_VAL;
		end else if (s2_reg == s3_reg) begin
			o_level <= s3_reg;
		end
	end
endmodule // ftac_sync3

//--- rtl/ftac_readout.sv
`timescale 1ns/100ps
module ftac_readout (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_start,
	input wire logic [ftac_pkg::TAP_W-1:0] i_taps,
	input wire logic [ftac_pkg::DIM_W-1:0] i_width,
	input wire logic [ftac_pkg::DIM_W-1:0] i_height,
	output logic o_busy,
	output logic o_done,
	output logic [ftac_pkg::DIM_W-1:0] o_col_base,
	output logic [ftac_pkg::DIM_W-1:0] o_line,
	output logic [ftac_pkg::MAX_TAPS-1:0] o_tap_mask,
	output logic [ftac_pkg::CYC_W-1:0] o_last_cycles
);
	import ftac_pkg::*;

	logic [CYC_W-1:0] cyc_reg;
	logic [DIM_W:0] col_sum;
	logic col_last;
	logic line_last;

	assign col_sum = {1'b0, o_col_base} + {{(DIM_W+1-TAP_W){1'b0}}, i_taps};
	assign col_last = col_sum >= {1'b0, i_width};
	assign line_last = ({1'b0, o_line} + {{DIM_W{1'b0}}, 1'b1}) >= {1'b0, i_height};

	// Lines are read in order, one tap group per beat; a start always restarts.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_col_base <= '0;
			o_line <= '0;
			cyc_reg <= '0;
			o_last_cycles <= '0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				o_busy <= 1'b1;
				o_col_base <= '0;
				o_line <= '0;
				cyc_reg <= {{(CYC_W-1){1'b0}}, 1'b1};
			end else if (o_busy) begin
				cyc_reg <= cyc_reg + {{(CYC_W-1){1'b0}}, 1'b1};
				if (col_last) begin
					o_col_base <= '0;
					if (line_last) begin
						o_busy <= 1'b0;
						o_done <= 1'b1;
						o_last_cycles <= cyc_reg;
					end else begin
						o_line <= o_line + {{(DIM_W-1){1'b0}}, 1'b1};
					end
				end else begin
					o_col_base <= col_sum[DIM_W-1:0];
				end
			end
		end
	end

	// Tap k carries column base+k, so adjacent pixels sit on adjacent taps.
	for (genvar k = 0; k < MAX_TAPS; k++) begin : g_tap
		localparam logic [DIM_W:0] TAP_IDX = (DIM_W+1)'(k);
		assign o_tap_mask[k] = o_busy && (TAP_IDX < {{(DIM_W+1-TAP_W){1'b0}}, i_taps})
			&& (({1'b0, o_col_base} + TAP_IDX) < {1'b0, i_width});
	end
endmodule // ftac_readout

//--- rtl/ftac_ctrl.sv
`timescale 1ns/100ps
// Function
// - Free-run and external trigger modes.
// - Short exposure: period is one cycle longer than transfer time.
// - Long exposure: period is exposure time plus overhead phase plus one cycle.
// - External mode: wait, expose, then transfer.
// - Trigger source is CC1 or connector.
// - Selectable trigger polarity.
// - Exposure from pulse width or program.
// - New exposure overlaps ongoing transfer.
// - Overlap sustains rate of one per transfer.
// - Programmed exposure ignores triggers during exposure.
// - Two, four, eight or ten taps.
// - Pixels interleaved across taps.
// - Serial command changes tap count, except in free-run when exposure plus overhead is no longer than transfer.
// - Global exposure, lines read in order.
// - Overhead phase then automatic readout.
module ftac_ctrl (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_mode_ext,
	input wire logic i_trig_src_ext,
	input wire logic i_trig_pol_high,
	input wire logic i_exp_src_pulse,
	input wire logic [ftac_pkg::EXP_W-1:0] i_exposure_us,
	input wire logic [ftac_pkg::DIM_W-1:0] i_width,
	input wire logic [ftac_pkg::DIM_W-1:0] i_height,
	input wire logic i_cc1,
	input wire logic i_ext_trig,
	input wire logic i_cfg_clk,
	input wire logic i_cfg_data,
	input wire logic i_cfg_sel_n,
	output logic o_exposing,
	output logic o_frame_overhead_phase,
	output logic o_frame_valid,
	output logic o_frame_done,
	output logic [ftac_pkg::DIM_W-1:0] o_col_base,
	output logic [ftac_pkg::DIM_W-1:0] o_line,
	output logic [ftac_pkg::MAX_TAPS-1:0] o_tap_mask,
	output logic [ftac_pkg::TAP_CODE_W-1:0] o_tap_code,
	output logic o_trig_ignored,
	output logic o_xfer_overrun
);
	import ftac_pkg::*;

	ftac_exp_state_t exp_state_reg;
	ftac_exp_state_t exp_state_next;

	logic cc1_s;
	logic ext_s;
	logic cfg_clk_s;
	logic cfg_data_s;
	logic cfg_sel_n_s;

	logic trig_act;
	logic trig_prev_reg;
	logic trig_edge;
	logic int_fire;
	logic start_exp;
	logic exp_end;
	logic fot_end;
	logic ro_start;
	logic ro_busy;
	logic ro_done;

	logic [CYC_W-1:0] exp_cycles;
	logic xfer_known_reg;
	logic [CYC_W-1:0] period;
	logic [CYC_W-1:0] period_cnt_reg;
	logic [CYC_W-1:0] exp_cnt_reg;
	logic [CYC_W-1:0] fot_cnt_reg;

	logic cfg_clk_prev_reg;
	logic cfg_sel_prev_reg;
	logic [CFG_CMD_W-1:0] cfg_shift_reg;
	logic [CFG_CNT_W-1:0] cfg_cnt_reg;
	logic tap_pend_reg;
	logic [TAP_CODE_W-1:0] tap_pend_code_reg;
	logic [TAP_W-1:0] taps;

	ftac_sync3 #(.RST_VAL(1'b0)) u_sync_cc1 (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_cc1),
		.o_level(cc1_s)
	);

	ftac_sync3 #(.RST_VAL(1'b0)) u_sync_ext (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_ext_trig),
		.o_level(ext_s)
	);

	// The serial clock and data pass equal stages, so data stays aligned to its clock.
	ftac_sync3 #(.RST_VAL(1'b0)) u_sync_cfg_clk (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_cfg_clk),
		.o_level(cfg_clk_s)
	);

	ftac_sync3 #(.RST_VAL(1'b0)) u_sync_cfg_data (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_cfg_data),
		.o_level(cfg_data_s)
	);

	ftac_sync3 #(.RST_VAL(1'b1)) u_sync_cfg_sel (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_cfg_sel_n),
		.o_level(cfg_sel_n_s)
	);

	assign trig_act = (i_trig_src_ext ? ext_s : cc1_s) ^ ~i_trig_pol_high;

	// Only the inactive-to-active edge starts anything.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			// Treat the pin as already active so, with active-low polarity, a held level after reset starts nothing.
			trig_prev_reg <= 1'b1;
		end else begin
			trig_prev_reg <= trig_act;
		end
	end

	assign trig_edge = trig_act & ~trig_prev_reg;

	assign start_exp = (exp_state_reg == EXP_IDLE) && (i_mode_ext ? trig_edge : int_fire);

	// Triggers arriving during exposure or overhead are dropped.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_trig_ignored <= 1'b0;
		end else begin
			o_trig_ignored <= i_mode_ext && trig_edge && (exp_state_reg != EXP_IDLE);
		end
	end

	assign exp_cycles = CYC_W'(i_exposure_us) * CYC_W'(CLK_PER_US);
	// Until one transfer has been timed, free-run waits for the readout to go idle.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			xfer_known_reg <= 1'b0;
		end else if (ro_done) begin
			xfer_known_reg <= 1'b1;
		end
	end

	// Free-run period is the longer of exposure and last transfer.
	logic [CYC_W-1:0] last_xfer;
	assign period = (exp_cycles > last_xfer) ? exp_cycles : last_xfer;

	// Counting from zero makes the period one cycle longer than the last transfer,
	// so the next readout start never lands on the last beat of the previous one.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			period_cnt_reg <= '0;
		end else if (start_exp) begin
			period_cnt_reg <= '0;
		end else if (period_cnt_reg != {CYC_W{1'b1}}) begin
			period_cnt_reg <= period_cnt_reg + {{(CYC_W-1){1'b0}}, 1'b1};
		end
	end

	assign int_fire = !i_mode_ext && (period_cnt_reg >= period) && (xfer_known_reg || !ro_busy);

	// Pulse-width exposure follows the trigger level.
	assign exp_end = (i_mode_ext && i_exp_src_pulse) ? !trig_act : (exp_cnt_reg >= exp_cycles);
	assign fot_end = fot_cnt_reg >= CYC_W'(FOT_CYCLES - 1);

	// Global exposure, overhead, then readout on its own.
	always_comb begin
		exp_state_next = exp_state_reg;
		case (exp_state_reg)
			EXP_IDLE: begin
				if (start_exp) begin
					exp_state_next = EXP_ACTIVE;
				end
			end
			EXP_ACTIVE: begin
				if (exp_end) begin
					exp_state_next = EXP_FOT;
				end
			end
			EXP_FOT: begin
				if (fot_end) begin
					exp_state_next = EXP_IDLE;
				end
			end
			default: begin
				exp_state_next = EXP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			exp_state_reg <= EXP_IDLE;
		end else begin
			exp_state_reg <= exp_state_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			exp_cnt_reg <= '0;
		end else if (start_exp) begin
			exp_cnt_reg <= {{(CYC_W-1){1'b0}}, 1'b1};
		end else if (exp_state_reg == EXP_ACTIVE) begin
			exp_cnt_reg <= exp_cnt_reg + {{(CYC_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fot_cnt_reg <= '0;
		end else if (exp_state_reg == EXP_FOT) begin
			fot_cnt_reg <= fot_cnt_reg + {{(CYC_W-1){1'b0}}, 1'b1};
		end else begin
			fot_cnt_reg <= '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_exposing <= 1'b0;
			o_frame_overhead_phase <= 1'b0;
		end else begin
			o_exposing <= exp_state_next == EXP_ACTIVE;
			o_frame_overhead_phase <= exp_state_next == EXP_FOT;
		end
	end

	// Exposure runs regardless of readout, so the two overlap.
	assign ro_start = (exp_state_reg == EXP_FOT) && fot_end;

	// A start while still reading restarts the frame; flag it.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_xfer_overrun <= 1'b0;
		end else begin
			o_xfer_overrun <= ro_start && ro_busy;
		end
	end

	// Serial command shifted MSB first while select is low.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_clk_prev_reg <= 1'b0;
			cfg_sel_prev_reg <= 1'b1;
			cfg_shift_reg <= '0;
			cfg_cnt_reg <= '0;
		end else begin
			cfg_clk_prev_reg <= cfg_clk_s;
			cfg_sel_prev_reg <= cfg_sel_n_s;
			if (cfg_sel_n_s) begin
				cfg_cnt_reg <= '0;
			end else if (cfg_clk_s && !cfg_clk_prev_reg) begin
				cfg_shift_reg <= {cfg_shift_reg[CFG_CMD_W-2:0], cfg_data_s};
				if (cfg_cnt_reg != {CFG_CNT_W{1'b1}}) begin
					cfg_cnt_reg <= cfg_cnt_reg + {{(CFG_CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// A new tap count waits for an idle readout so no frame mixes two layouts.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tap_pend_reg <= 1'b0;
			tap_pend_code_reg <= RST_TAP_CODE;
			o_tap_code <= RST_TAP_CODE;
		end else begin
			if (cfg_sel_n_s && !cfg_sel_prev_reg && (cfg_cnt_reg == CFG_CMD_BITS)
				&& (cfg_shift_reg[CFG_OP_MSB:CFG_OP_LSB] == CFG_OP_TAP)) begin
				tap_pend_reg <= 1'b1;
				tap_pend_code_reg <= cfg_shift_reg[TAP_CODE_W-1:0];
			end else if (tap_pend_reg && !ro_busy && !ro_start) begin
				tap_pend_reg <= 1'b0;
				o_tap_code <= tap_pend_code_reg;
			end
		end
	end

	always_comb begin
		case (o_tap_code)
			TAP_CODE_2: taps = TAPS_2;
			TAP_CODE_4: taps = TAPS_4;
			TAP_CODE_8: taps = TAPS_8;
			TAP_CODE_10: taps = TAPS_10;
			default: taps = TAPS_2;
		endcase
	end

	ftac_readout u_readout (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_start(ro_start),
		.i_taps(taps),
		.i_width(i_width),
		.i_height(i_height),
		.o_busy(ro_busy),
		.o_done(ro_done),
		.o_col_base(o_col_base),
		.o_line(o_line),
		.o_tap_mask(o_tap_mask),
		.o_last_cycles(last_xfer)
	);

	assign o_frame_valid = ro_busy;
	assign o_frame_done = ro_done;
endmodule // ftac_ctrl

//--- dv/ftac_ctrl_monitor.sv
`timescale 1ns/100ps
module ftac_ctrl_monitor (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic o_exposing,
	input wire logic o_frame_overhead_phase,
	input wire logic o_frame_valid,
	input wire logic o_frame_done,
	input wire logic [ftac_pkg::DIM_W-1:0] o_col_base,
	input wire logic [ftac_pkg::DIM_W-1:0] o_line,
	input wire logic [ftac_pkg::MAX_TAPS-1:0] o_tap_mask,
	input wire logic [ftac_pkg::TAP_CODE_W-1:0] o_tap_code,
	input wire logic o_trig_ignored
);
	import ftac_pkg::*;
	logic [15:0] fot_cnt;
	logic [TAP_W-1:0] ntaps;
	logic busy_exp;
	assign busy_exp = o_exposing | o_frame_overhead_phase;
	assign ntaps = (o_tap_code == TAP_CODE_2) ? TAPS_2 : (o_tap_code == TAP_CODE_4) ? TAPS_4 :
		(o_tap_code == TAP_CODE_8) ? TAPS_8 : TAPS_10;
	// Counts the cycles of the running overhead phase.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !o_frame_overhead_phase) begin
			fot_cnt <= 16'h0;
		end else begin
			fot_cnt <= fot_cnt + 16'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_exp_to_fot: assert property ($fell(o_exposing) |-> o_frame_overhead_phase)
		else $error("overhead phase does not follow exposure");
	a_fot_length: assert property ($fell(o_frame_overhead_phase) |-> fot_cnt == 16'(FOT_CYCLES))
		else $error("overhead phase length wrong");
	a_fot_to_readout: assert property ($fell(o_frame_overhead_phase) |-> ##[0:2] o_frame_valid)
		else $error("readout does not follow overhead phase");
	a_one_phase: assert property (!(o_exposing && o_frame_overhead_phase))
		else $error("exposure and overhead phase together");
	a_valid_end_done: assert property ($fell(o_frame_valid) |-> o_frame_done)
		else $error("frame end without done pulse");
	a_done_single: assert property (o_frame_done |=> !o_frame_done)
		else $error("done pulse longer than one cycle");
	a_mask_in_taps: assert property (o_frame_valid |-> o_tap_mask[0] && (o_tap_mask >> ntaps) == '0)
		else $error("tap mask outside tap count");
	a_col_interleave: assert property (o_frame_valid && $past(o_frame_valid) && o_line == $past(o_line)
		|-> o_col_base == $past(o_col_base) + DIM_W'(ntaps))
		else $error("column step differs from tap count");
	a_ign_busy: assert property (o_trig_ignored |-> $past(busy_exp) || $past(busy_exp, 2))
		else $error("trigger ignored while idle");
	c_overlap: cover property (o_exposing && o_frame_valid);
	c_ignored: cover property (o_trig_ignored);
	c_ten_taps: cover property (o_frame_done && o_tap_code == TAP_CODE_10);
endmodule // ftac_ctrl_monitor

bind ftac_ctrl ftac_ctrl_monitor mon_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.o_exposing(o_exposing), .o_frame_overhead_phase(o_frame_overhead_phase),
	.o_frame_valid(o_frame_valid), .o_frame_done(o_frame_done), .o_col_base(o_col_base),
	.o_line(o_line), .o_tap_mask(o_tap_mask), .o_tap_code(o_tap_code),
	.o_trig_ignored(o_trig_ignored));

//--- dv/ftac_grabber.sv
`timescale 1ns/100ps
module ftac_grabber (
	output logic o_cc1,
	output logic o_ext_trig,
	output logic o_cfg_clk,
	output logic o_cfg_data,
	output logic o_cfg_sel_n
);
	initial begin
		o_cc1 = 1'b0;
		o_ext_trig = 1'b0;
		o_cfg_clk = 1'b0;
		o_cfg_data = 1'b1;
		o_cfg_sel_n = 1'b1;
	end
	task automatic set_pin(input logic ext, input logic lvl);
		if (ext) begin
			o_ext_trig = lvl;
		end else begin
			o_cc1 = lvl;
		end
	endtask
	task automatic pulse(input logic ext, input logic act, input int len);
		set_pin(ext, act);
		#(len * 25);
		set_pin(ext, ~act);
	endtask
	// The link clock only runs inside a command; data is inverted once deselected.
	task automatic send_cmd(input logic [7:0] cmd, input int nbits);
		#3;
		o_cfg_sel_n = 1'b0;
		for (int i = 7; i > 7 - nbits; i--) begin
			o_cfg_data = cmd[i];
			#100 o_cfg_clk = 1'b1;
			#100 o_cfg_clk = 1'b0;
		end
		#100 o_cfg_sel_n = 1'b1;
		o_cfg_data = ~o_cfg_data;
		// Keep the deselect long enough for the block to see it between commands.
		#300;
	endtask
endmodule // ftac_grabber

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ftac_pkg::*;
	logic i_clk, i_sys_rst, i_mode_ext, i_trig_src_ext, i_trig_pol_high, i_exp_src_pulse;
	logic [EXP_W-1:0] i_exposure_us;
	logic [DIM_W-1:0] i_width, i_height;
	wire logic cc1, ext_trig, cfg_clk, cfg_data, cfg_sel_n;
	logic exposing, frame_overhead_phase, valid, done, ign, ign_seen, ov_seen, ovr, ovr_seen;
	logic [TAP_CODE_W-1:0] tap_code;
	int fail_count, n_compared;
	ftac_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode_ext(i_mode_ext),
		.i_trig_src_ext(i_trig_src_ext), .i_trig_pol_high(i_trig_pol_high),
		.i_exp_src_pulse(i_exp_src_pulse), .i_exposure_us(i_exposure_us), .i_width(i_width),
		.i_height(i_height), .i_cc1(cc1), .i_ext_trig(ext_trig), .i_cfg_clk(cfg_clk),
		.i_cfg_data(cfg_data), .i_cfg_sel_n(cfg_sel_n), .o_exposing(exposing),
		.o_frame_overhead_phase(frame_overhead_phase), .o_frame_valid(valid), .o_frame_done(done),
		.o_col_base(), .o_line(), .o_tap_mask(), .o_tap_code(tap_code),
		.o_trig_ignored(ign), .o_xfer_overrun(ovr));
	ftac_grabber fg_u (.o_cc1(cc1), .o_ext_trig(ext_trig), .o_cfg_clk(cfg_clk),
		.o_cfg_data(cfg_data), .o_cfg_sel_n(cfg_sel_n));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (ign) ign_seen <= 1'b1;
		if (exposing && valid) ov_seen <= 1'b1;
		if (ovr) ovr_seen <= 1'b1;
	end
	function automatic logic sig(input int w);
		case (w)
			0: return exposing;
			1: return frame_overhead_phase;
			2: return valid;
			default: return done;
		endcase
	endfunction
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic in_rng(input string nm, input int lo, input int hi, input int g);
		chk(nm, 32'd1, {31'd0, (g >= lo && g <= hi)});
	endtask
	task automatic wait_sig(input int w, input logic v, input int lim, output int n);
		n = 0;
		while (sig(w) !== v && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			$display("CHECK FAILED wait %0d expected %0b seen %0b", w, v, sig(w));
			complete_run();
		end
	endtask
	task automatic cfg(input logic m, input logic s, input logic p, input logic ps, input int us);
		int n;
		@(posedge i_clk);
		i_mode_ext <= m;
		i_trig_src_ext <= s;
		i_trig_pol_high <= p;
		i_exp_src_pulse <= ps;
		i_exposure_us <= EXP_W'(us);
		repeat (20) @(negedge i_clk);
		wait_sig(0, 1'b0, 5000, n);
		wait_sig(1, 1'b0, 5000, n);
		wait_sig(2, 1'b0, 5000, n);
	endtask
	task automatic t_free(input int us, input int lo, input int hi);
		int n1, n2;
		cfg(1'b0, 1'b0, 1'b1, 1'b0, us);
		repeat (3) begin
			wait_sig(0, 1'b1, 5000, n1);
			wait_sig(0, 1'b0, 5000, n1);
		end
		wait_sig(0, 1'b1, 5000, n2);
		in_rng("free-run period", lo, hi, n1 + n2);
	endtask
	task automatic t_prog();
		int n;
		logic seen;
		cfg(1'b1, 1'b0, 1'b1, 1'b0, 5);
		chk("idle without trigger", 0, exposing);
		ign_seen = 1'b0;
		fork
			begin
				fg_u.pulse(1'b0, 1'b1, 30);
				#(30 * 25) fg_u.pulse(1'b0, 1'b1, 10);
			end
		join_none
		wait_sig(0, 1'b1, 20, n);
		wait_sig(0, 1'b0, 400, n);
		in_rng("programmed exposure", 199, 201, n);
		chk("retrigger flagged", 1, ign_seen);
		seen = 1'b0;
		repeat (900) begin
			@(negedge i_clk);
			seen |= exposing;
		end
		chk("single exposure", 0, seen);
	endtask
	task automatic t_pulse();
		int n;
		fg_u.set_pin(1'b1, 1'b1);
		cfg(1'b1, 1'b1, 1'b0, 1'b1, 1);
		fg_u.pulse(1'b0, 1'b1, 30);
		repeat (10) @(negedge i_clk);
		chk("unselected source", 0, exposing);
		fork
			fg_u.pulse(1'b1, 1'b0, 100);
		join_none
		wait_sig(0, 1'b1, 20, n);
		wait_sig(0, 1'b0, 200, n);
		in_rng("pulse-width exposure", 98, 102, n);
	endtask
	task automatic t_taps();
		int n;
		int tp[4] = '{2, 4, 8, 10};
		cfg(1'b1, 1'b0, 1'b1, 1'b0, 1);
		for (int i = 0; i < 4; i++) begin
			fg_u.send_cmd({CFG_OP_TAP, 2'h0, 2'(i)}, 8);
			repeat (10) @(negedge i_clk);
			chk("tap code", i, tap_code);
			fork
				fg_u.pulse(1'b0, 1'b1, 10);
			join_none
			wait_sig(2, 1'b1, 800, n);
			wait_sig(2, 1'b0, 100, n);
			chk("beats", ((25 + tp[i] - 1) / tp[i]) * 2, n);
			chk("frame done", 1, done);
		end
		fg_u.send_cmd({4'h5, 4'h1}, 8);
		fg_u.send_cmd({CFG_OP_TAP, 4'h2}, 7);
		repeat (10) @(negedge i_clk);
		chk("tap code kept", 3, tap_code);
	endtask
	initial begin
		fail_count = 0;
		n_compared = 0;
		ign_seen = 1'b0;
		ov_seen = 1'b0;
		ovr_seen = 1'b0;
		i_sys_rst = 1'b1;
		i_mode_ext = 1'b0;
		i_trig_src_ext = 1'b0;
		i_trig_pol_high = 1'b1;
		i_exp_src_pulse = 1'b0;
		i_exposure_us = EXP_W'(1);
		i_width = DIM_W'(500);
		i_height = DIM_W'(4);
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_free(1, 1000, 1002);
		chk("exposure overlaps readout", 1, ov_seen);
		t_free(75, 3000, 3402);
		chk("transfer overrun", 0, ovr_seen);
		@(posedge i_clk);
		i_width <= DIM_W'(25);
		i_height <= DIM_W'(2);
		t_prog();
		t_pulse();
		t_taps();
		complete_run();
	end
endmodule // tb_top
